// File: core/ssc_pkg.sv
// Purpose: Shared constants for the spread selection serial configuration block
// Assumes: 40 MHz core clock, two-wire target sampled on that clock
// Notes:   Lookup entries pack {center_flag, percent_in_hundredths[9:0]}
package ssc_pkg;

  // Serial target addresses (write, read)
  localparam logic [7:0] WR_ADDR = 8'hd4;
  localparam logic [7:0] RD_ADDR = 8'hd5;

  // Register indices of the three mapped bytes
  localparam logic [7:0] IDX_CTRL  = 8'h00;
  localparam logic [7:0] IDX_OUTS  = 8'h01;
  localparam logic [7:0] IDX_RSVD  = 8'h02;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h86;
  localparam logic [7:0] OUTS_RST  = 8'hcf;
  localparam logic [7:0] RSVD_RST  = 8'hff;
  localparam logic [7:0] COUNT_RST = 8'h03;

  // Writable masks
  localparam logic [7:0] OUTS_WMASK = 8'hcc;
  localparam logic [7:0] RSVD_WMASK = 8'h7f;

  // Control byte field positions
  localparam int CTRL_SW_SEL  = 0;
  localparam int CTRL_SPR_EN  = 1;
  localparam int CTRL_PD_LOW  = 2;
  localparam int CTRL_CODE4   = 3;
  localparam int CTRL_CODE3   = 4;
  localparam int CTRL_CODE2   = 5;
  localparam int CTRL_CODE1   = 6;
  localparam int CTRL_CODE0   = 7;

  // Output byte field positions
  localparam int OUTS_REF_EN   = 7;
  localparam int OUTS_REF_SLEW = 6;
  localparam int OUTS_STRAP_HI = 5;
  localparam int OUTS_STRAP_LO = 4;
  localparam int OUTS_CLK_SLEW = 3;
  localparam int OUTS_CLK_EN   = 2;

  // Power-down entry bound; met by the two-flop sync
  localparam int PD_MAX_LATENCY_NS = 1800000;
  localparam int CLK_PERIOD_NS     = 25;
  localparam int PD_MAX_CYCLES     = PD_MAX_LATENCY_NS / CLK_PERIOD_NS;

  // Strap capture waits for the pin synchroniser to fill
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // Fixed 32-entry selection table
  localparam logic [10:0] SPREAD_ROM [32] = '{
    11'h03c, 11'h050, 11'h064, 11'h07d, 11'h096, 11'h0c8, 11'h432, 11'h464,
    11'h03c, 11'h064, 11'h050, 11'h41e, 11'h096, 11'h0af, 11'h0c8, 11'h0fa,
    11'h12c, 11'h07d, 11'h428, 11'h432, 11'h446, 11'h464, 11'h478, 11'h496,
    11'h03c, 11'h050, 11'h064, 11'h07d, 11'h096, 11'h0c8, 11'h432, 11'h464
  };

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RXEND  = 3'b010,
    ST_ACK    = 3'b011,
    ST_TX     = 3'b100,
    ST_RACK   = 3'b101,
    ST_IGNORE = 3'b110
  } ssc_state_e;

  typedef enum logic [1:0] {
    ROLE_ADDR  = 2'b00,
    ROLE_INDEX = 2'b01,
    ROLE_COUNT = 2'b10,
    ROLE_DATA  = 2'b11
  } ssc_role_e;

endpackage

// File: core/ssc_serial_config.sv
// Purpose: Two-wire configuration target and selection logic of a spread clock generator
// Assumes: core_clk far faster than the serial clock; straps valid at reset release
// Notes:   Analog modulation is outside; this block presents the selected table entry
//
// Behaviour
// - Start opens, stop closes one indexed transaction
// - Acknowledge matching write address after start
// - Index byte acknowledged and loaded as pointer
// - Count byte acknowledged; expect that many bytes
// - Acknowledge, store, advance pointer per data byte
// - Fixed 32-entry table by 5-bit code
// - Low three code bits only from register
// - Code bits 3,4 from latched straps
// - Straps drive upper bits until software select
// - Low code bits reset to 001
// - Strap 10 yields 27 MHz, 1.25% down
// - Other strap pairs give their documented modes
// - Shared pins: strap inputs, then clock outputs
// - Power-down input acts asynchronously, stops clocks
// - Low-power entry within maximum latency
// - Read: count byte, then consecutive register bytes
`timescale 1ns/1ps
module ssc_serial_config (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Serial bus
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe,
  // Shared pin 4: strap in, modulated clock out
  input  wire logic        strap_select_low,
  output logic             modulated_clock_out,
  output logic             modulated_clock_oe,
  // Shared pin 5: strap in, reference clock out
  input  wire logic        strap_select_high,
  output logic             reference_clock_out,
  output logic             reference_clock_oe,
  // Reference and power-down
  input  wire logic        reference_clock_in,
  input  wire logic        power_down_n,
  // Selection toward the analog modulator
  output logic [4:0]       spread_code,
  output logic             spread_center,
  output logic [9:0]       spread_pct_hundredths,
  output logic             spread_enable,
  output logic             low_power
);

  typedef struct packed {
    logic [1:0]  scl_s;
    logic        scl_d;
    logic [1:0]  sda_s;
    logic        sda_d;
    logic [1:0]  pd_s;
    logic [1:0]  ref_s;
    logic [1:0]  slo_s;
    logic [1:0]  shi_s;
    logic [1:0]  cap_cnt;
    logic        strap_done;
    logic        strap_lo;
    logic        strap_hi;
    ssc_pkg::ssc_state_e st;
    ssc_pkg::ssc_role_e  role;
    logic        rd;
    logic        tx_count;
    logic        ack;
    logic [2:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic [7:0]  left;
    logic [7:0]  cnt;
    logic        sda_oe;
    logic [7:0]  ctrl;
    logic [7:0]  outs;
    logic [7:0]  rsvd;
    logic [4:0]  code;
    logic [10:0] entry;
    logic        clk_out;
  } ssc_state_s;

  ssc_state_s s_q;
  ssc_state_s s_d;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic       pd_active;

  // Edge detectors read only the second sync stage and later
  assign scl_rise   = s_q.scl_s[1] & ~s_q.scl_d;
  assign scl_fall   = ~s_q.scl_s[1] & s_q.scl_d;
  assign start_cond = s_q.scl_s[1] & s_q.scl_d & s_q.sda_d & ~s_q.sda_s[1];
  assign stop_cond  = s_q.scl_s[1] & s_q.scl_d & ~s_q.sda_d & s_q.sda_s[1];
  assign rx_byte    = {s_q.shreg[6:0], s_q.sda_s[1]};

  always_comb begin
    unique case (s_q.ptr)
      ssc_pkg::IDX_CTRL: rd_byte = s_q.ctrl;
      ssc_pkg::IDX_OUTS: rd_byte = {s_q.outs[7:6], s_q.strap_hi, s_q.strap_lo,
                                    s_q.outs[3:0]};
      ssc_pkg::IDX_RSVD: rd_byte = s_q.rsvd;
      default:           rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.scl_s = {s_q.scl_s[0], serial_clock_in};
    s_d.sda_s = {s_q.sda_s[0], serial_data_line_in};
    s_d.scl_d = s_q.scl_s[1];
    s_d.sda_d = s_q.sda_s[1];
    s_d.pd_s  = {s_q.pd_s[0], ~power_down_n};
    s_d.ref_s = {s_q.ref_s[0], reference_clock_in};
    s_d.slo_s = {s_q.slo_s[0], strap_select_low};
    s_d.shi_s = {s_q.shi_s[0], strap_select_high};

    // Straps sampled once while pins are still inputs
    if (!s_q.strap_done) begin
      if (s_q.cap_cnt == ssc_pkg::STRAP_WAIT) begin
        s_d.strap_done = 1'b1;
        s_d.strap_lo   = s_q.slo_s[1];
        s_d.strap_hi   = s_q.shi_s[1];
      end else begin
        s_d.cap_cnt = s_q.cap_cnt + 2'h1;
      end
    end

    if (stop_cond) begin
      s_d.st     = ssc_pkg::ST_IDLE;
      s_d.sda_oe = 1'b0;
    end else if (start_cond) begin
      s_d.st     = ssc_pkg::ST_RX;
      s_d.role   = ssc_pkg::ROLE_ADDR;
      s_d.bitcnt = 3'h0;
      s_d.sda_oe = 1'b0;
    end else begin
      unique case (s_q.st)
        ssc_pkg::ST_IDLE, ssc_pkg::ST_IGNORE: s_d.sda_oe = 1'b0;
        ssc_pkg::ST_RX: if (scl_rise) begin
          s_d.shreg  = rx_byte;
          s_d.bitcnt = s_q.bitcnt + 3'h1;
          if (s_q.bitcnt == 3'h7) begin
            s_d.st  = ssc_pkg::ST_RXEND;
            s_d.ack = 1'b1;
            unique case (s_q.role)
              ssc_pkg::ROLE_ADDR: begin
                if (rx_byte == ssc_pkg::WR_ADDR) begin
                  s_d.rd   = 1'b0;
                  s_d.role = ssc_pkg::ROLE_INDEX;
                end else if (rx_byte == ssc_pkg::RD_ADDR) begin
                  s_d.rd       = 1'b1;
                  s_d.tx_count = 1'b1;
                end else begin
                  s_d.ack = 1'b0;
                end
              end
              ssc_pkg::ROLE_INDEX: begin
                s_d.ptr  = rx_byte;
                s_d.role = ssc_pkg::ROLE_COUNT;
              end
              ssc_pkg::ROLE_COUNT: begin
                s_d.cnt  = rx_byte;
                s_d.left = rx_byte;
                s_d.role = ssc_pkg::ROLE_DATA;
              end
              ssc_pkg::ROLE_DATA: begin
                // Bytes beyond the announced count are refused
                if (s_q.left == 8'h00) begin
                  s_d.ack = 1'b0;
                end else begin
                  s_d.left = s_q.left - 8'h01;
                  s_d.ptr  = s_q.ptr + 8'h01;
                  unique case (s_q.ptr)
                    ssc_pkg::IDX_CTRL: s_d.ctrl = rx_byte;
                    ssc_pkg::IDX_OUTS: s_d.outs = (s_q.outs & ~ssc_pkg::OUTS_WMASK)
                                                | (rx_byte & ssc_pkg::OUTS_WMASK);
                    ssc_pkg::IDX_RSVD: s_d.rsvd = (s_q.rsvd & ~ssc_pkg::RSVD_WMASK)
                                                | (rx_byte & ssc_pkg::RSVD_WMASK);
                    default: ;
                  endcase
                end
              end
            endcase
          end
        end
        ssc_pkg::ST_RXEND: if (scl_fall) begin
          s_d.sda_oe = s_q.ack;
          s_d.st     = s_q.ack ? ssc_pkg::ST_ACK : ssc_pkg::ST_IGNORE;
        end
        ssc_pkg::ST_ACK: if (scl_fall) begin
          s_d.bitcnt = 3'h0;
          if (s_q.rd) begin
            // Count goes first, then register bytes from the pointer
            s_d.shreg    = s_q.tx_count ? s_q.cnt : rd_byte;
            s_d.sda_oe   = s_q.tx_count ? ~s_q.cnt[7] : ~rd_byte[7];
            s_d.ptr      = s_q.tx_count ? s_q.ptr : s_q.ptr + 8'h01;
            s_d.tx_count = 1'b0;
            s_d.st       = ssc_pkg::ST_TX;
          end else begin
            s_d.sda_oe = 1'b0;
            s_d.st     = ssc_pkg::ST_RX;
          end
        end
        ssc_pkg::ST_TX: if (scl_fall) begin
          if (s_q.bitcnt == 3'h7) begin
            s_d.sda_oe = 1'b0;
            s_d.st     = ssc_pkg::ST_RACK;
          end else begin
            s_d.bitcnt = s_q.bitcnt + 3'h1;
            s_d.shreg  = {s_q.shreg[6:0], 1'b0};
            s_d.sda_oe = ~s_q.shreg[6];
          end
        end
        ssc_pkg::ST_RACK: begin
          if (scl_rise) begin
            s_d.ack = ~s_q.sda_s[1];
          end
          if (scl_fall) begin
            s_d.st = ssc_pkg::ST_IGNORE;
            if (s_q.ack) begin
              // Ninth clock has already ended, so the next byte loads at once
              s_d.bitcnt = 3'h0;
              s_d.shreg  = rd_byte;
              s_d.sda_oe = ~rd_byte[7];
              s_d.ptr    = s_q.ptr + 8'h01;
              s_d.st     = ssc_pkg::ST_TX;
            end
          end
        end
        default: s_d.st = ssc_pkg::ST_IDLE;
      endcase
    end

    // Upper bits follow straps until software selection is set
    s_d.code = {s_q.ctrl[ssc_pkg::CTRL_SW_SEL] ? s_q.ctrl[ssc_pkg::CTRL_CODE4]
                                                : s_q.strap_hi,
                s_q.ctrl[ssc_pkg::CTRL_SW_SEL] ? s_q.ctrl[ssc_pkg::CTRL_CODE3]
                                                : s_q.strap_lo,
                s_q.ctrl[ssc_pkg::CTRL_CODE2],
                s_q.ctrl[ssc_pkg::CTRL_CODE1],
                s_q.ctrl[ssc_pkg::CTRL_CODE0]};
    s_d.entry   = ssc_pkg::SPREAD_ROM[s_q.code];
    s_d.clk_out = s_q.ref_s[1] & ~s_q.pd_s[1];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.scl_s    <= 2'h3;
      s_q.scl_d    <= 1'b1;
      s_q.sda_s    <= 2'h3;
      s_q.sda_d    <= 1'b1;
      s_q.st       <= ssc_pkg::ST_IDLE;
      s_q.role     <= ssc_pkg::ROLE_ADDR;
      s_q.cnt      <= ssc_pkg::COUNT_RST;
      s_q.ctrl     <= ssc_pkg::CTRL_RST;
      s_q.outs     <= ssc_pkg::OUTS_RST;
      s_q.rsvd     <= ssc_pkg::RSVD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Raw pin gates the drivers so power-down needs no clock edge
  assign pd_active = ~power_down_n | s_q.pd_s[1];

  always_comb begin
    serial_data_line_out  = 1'b0;
    serial_data_line_oe   = s_q.sda_oe;
    modulated_clock_out   = s_q.clk_out & ~pd_active;
    reference_clock_out   = s_q.clk_out & ~pd_active;
    // In power-down the pins float or are held low per control bit
    modulated_clock_oe    = s_q.strap_done & (pd_active ? s_q.ctrl[ssc_pkg::CTRL_PD_LOW]
                                             : s_q.outs[ssc_pkg::OUTS_CLK_EN]);
    reference_clock_oe    = s_q.strap_done & (pd_active ? s_q.ctrl[ssc_pkg::CTRL_PD_LOW]
                                             : s_q.outs[ssc_pkg::OUTS_REF_EN]);
    spread_code           = s_q.code;
    spread_center         = s_q.entry[10];
    spread_pct_hundredths = s_q.entry[9:0];
    spread_enable         = s_q.ctrl[ssc_pkg::CTRL_SPR_EN];
    low_power             = s_q.pd_s[1];
  end

endmodule

// File: test/ssc_chk_sva.sv
// Purpose: Port assertions for the serial configuration block
// Assumes: One clock domain, rst_n synchronous active low
// Notes:   Latency bounds sit far inside the pin limit
`timescale 1ns/1ps
module ssc_chk_sva (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Watched ports
  input wire logic       serial_clock_in,
  input wire logic       serial_data_line_oe,
  input wire logic       modulated_clock_out,
  input wire logic       modulated_clock_oe,
  input wire logic       reference_clock_out,
  input wire logic       power_down_n,
  input wire logic [4:0] spread_code,
  input wire logic       spread_center,
  input wire logic [9:0] spread_pct_hundredths,
  input wire logic       low_power
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_held(logic [4:0] c);
    (spread_code == c) [*3];
  endsequence
  sequence s_inputs;
    !modulated_clock_oe [*2];
  endsequence
  AST_PD_ENTER: assert property ($fell(power_down_n) |-> ##[1:4] low_power)
    else $error("low power late");
  AST_PD_LEAVE: assert property ($rose(power_down_n) |-> ##[1:4] !low_power)
    else $error("low power stuck");
  AST_PD_CLK: assert property (!power_down_n && !$past(power_down_n)
    |-> !modulated_clock_out) else $error("clock out in power down");
  AST_PD_REF: assert property (!power_down_n && !$past(power_down_n)
    |-> !reference_clock_out) else $error("reference out in power down");
  AST_CODE_INIT: assert property ($rose(rst_n) |-> ##[4:8] spread_code[2:0] == 3'h1)
    else $error("low code bits not 001");
  AST_PIN_TURN: assert property ($rose(rst_n) |-> s_inputs ##[1:6] modulated_clock_oe)
    else $error("pin turnaround wrong");
  AST_ENTRY_DEF: assert property (s_held(5'h11) |-> !spread_center &&
    spread_pct_hundredths == 10'h07d) else $error("entry 17 wrong");
  AST_ENTRY_00: assert property (s_held(5'h01) |-> !spread_center &&
    spread_pct_hundredths == 10'h050) else $error("entry 1 wrong");
  AST_ENTRY_CTR: assert property (s_held(5'h0b) |-> spread_center &&
    spread_pct_hundredths == 10'h01e) else $error("entry 11 wrong");
  AST_SDA_LOW: assert property ($changed(serial_data_line_oe) |-> !serial_clock_in)
    else $error("data moved with clock high");
endmodule
bind ssc_serial_config ssc_chk_sva u_chk (
  .core_clk, .rst_n, .serial_clock_in, .serial_data_line_oe, .modulated_clock_out,
  .modulated_clock_oe, .reference_clock_out, .power_down_n, .spread_code,
  .spread_center, .spread_pct_hundredths, .low_power
);

// File: test/ssc_host_model.sv
// Purpose: Two-wire host for indexed block transfers
// Assumes: Bench resolves the open-drain data line with a pull-up
// Notes:   Half bit of 12 cycles stays above the 10-cycle minimum
`timescale 1ns/1ps
module ssc_host_model (
  // Clock
  input wire logic core_clk,
  // Bus
  input wire logic sda,
  output logic     scl,
  output logic     sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (12) @(posedge core_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    @(posedge core_clk);
    sda_low <= !b;
    half();
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    @(posedge core_clk);
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge core_clk);
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// File: test/tb_ssc_serial_config.sv
// Purpose: Self-checking bench for the serial configuration block
// Assumes: Straps resolve onto the shared pins while those float
// Notes:   Straps are only re-latched by a fresh power-up
`timescale 1ns/1ps
module tb_ssc_serial_config;
  logic       core_clk, rst_n, power_down_n, strap_lo, strap_hi, scl, host_low, sda;
  logic       sda_out, sda_oe, mod_out, mod_oe, ref_out, ref_oe, center, spr_en;
  logic       low_power, pin4, pin5, ack, hi, lo;
  logic [2:0] ref_div;
  logic [4:0] code;
  logic [9:0] pct;
  logic [7:0] rx;
  int         num_errors, num_checks;
  assign sda  = !(host_low || (sda_oe && !sda_out));
  assign pin4 = mod_oe ? mod_out : strap_lo;
  assign pin5 = ref_oe ? ref_out : strap_hi;
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) ref_div <= ref_div + 3'h1;
  ssc_host_model host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(host_low));
  ssc_serial_config dut (
    .core_clk(core_clk), .rst_n(rst_n), .serial_clock_in(scl), .serial_data_line_in(sda),
    .serial_data_line_out(sda_out), .serial_data_line_oe(sda_oe), .strap_select_low(pin4),
    .modulated_clock_out(mod_out), .modulated_clock_oe(mod_oe), .strap_select_high(pin5),
    .reference_clock_out(ref_out), .reference_clock_oe(ref_oe),
    .reference_clock_in(ref_div[2]), .power_down_n(power_down_n), .spread_code(code),
    .spread_center(center), .spread_pct_hundredths(pct), .spread_enable(spr_en),
    .low_power(low_power)
  );
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic power_up(input logic [1:0] st);
    @(posedge core_clk);
    rst_n <= 1'b0;
    strap_hi <= st[1];
    strap_lo <= st[0];
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge core_clk);
  endtask
  task automatic chk_sel(input logic [4:0] c, input logic cen, input logic [9:0] p);
    settle(4);
    chk_vec({11'h000, code}, {11'h000, c}, "selection code");
    chk_vec({5'h00, center, pct}, {5'h00, cen, p}, "table entry");
  endtask
  task automatic wr(input logic [7:0] n, input logic [7:0] x, input logic [7:0] d[$]);
    host.start();
    host.wbyte(8'hd4, ack);
    chk_bit(ack, 1'b1, "address ack");
    host.wbyte(n, ack);
    chk_bit(ack, 1'b1, "index ack");
    host.wbyte(x, ack);
    chk_bit(ack, 1'b1, "count ack");
    foreach (d[i]) begin
      host.wbyte(d[i], ack);
      chk_bit(ack, i < x, "data ack");
    end
    host.stop();
  endtask
  task automatic rd(input logic [7:0] n, input logic [7:0] cnt, input logic [7:0] e[$]);
    host.start();
    host.wbyte(8'hd4, ack);
    host.wbyte(n, ack);
    host.start();
    host.wbyte(8'hd5, ack);
    chk_bit(ack, 1'b1, "read address ack");
    host.rbyte(1'b1, rx);
    chk_vec({8'h00, rx}, {8'h00, cnt}, "count byte");
    foreach (e[i]) begin
      host.rbyte(i < e.size() - 1, rx);
      chk_vec({8'h00, rx}, {8'h00, e[i]}, "read byte");
    end
    host.stop();
  endtask
  initial begin
    rst_n = 1'b0;
    power_down_n = 1'b1;
    strap_lo = 1'b0;
    strap_hi = 1'b1;
    ref_div = 3'h0;
    num_errors = 0;
    num_checks = 0;
    power_up(2'b00);
    chk_sel(5'h01, 1'b0, 10'h050);
    chk_bit(mod_oe, 1'b1, "pin 4 not driving");
    power_up(2'b01);
    chk_sel(5'h09, 1'b0, 10'h064);
    power_up(2'b11);
    chk_sel(5'h19, 1'b0, 10'h050);
    power_up(2'b10);
    chk_sel(5'h11, 1'b0, 10'h07d);
    rd(8'h00, 8'h03, '{8'h86, 8'hef, 8'hff});
    // Select first, code second, as software must
    wr(8'h00, 8'h01, '{8'h87});
    chk_sel(5'h01, 1'b0, 10'h050);
    wr(8'h00, 8'h01, '{8'hd7});
    chk_sel(5'h0b, 1'b1, 10'h01e);
    chk_bit(spr_en, 1'b1, "spread enable not set");
    // Fourth byte exceeds the count and must be refused
    wr(8'h00, 8'h03, '{8'h7d, 8'h44, 8'h55, 8'haa});
    chk_sel(5'h1e, 1'b1, 10'h032);
    chk_bit(spr_en, 1'b0, "spread enable not cleared");
    chk_bit(ref_oe, 1'b0, "reference pin driving");
    rd(8'h00, 8'h03, '{8'h7d, 8'h67, 8'hd5});
    wr(8'h00, 8'h01, '{8'h66});
    chk_sel(5'h16, 1'b1, 10'h078);
    host.start();
    for (int i = 0; i < 4; i++) begin
      host.wbyte(i == 0 ? 8'ha0 : 8'h00, ack);
      chk_bit(ack, 1'b0, "foreign transfer acked");
    end
    host.stop();
    rd(8'h00, 8'h01, '{8'h62 | 8'h04});
    // Pins float in power-down so fresh strap levels reach the inputs
    wr(8'h00, 8'h01, '{8'h62});
    settle(2);
    hi = 1'b0;
    lo = 1'b0;
    repeat (24) begin
      @(negedge core_clk);
      hi = hi | (mod_out & ref_out);
      lo = lo | !(mod_out | ref_out);
    end
    chk_bit(hi & lo, 1'b1, "clock not running");
    @(posedge core_clk);
    power_down_n <= 1'b0;
    settle(4);
    chk_bit(low_power, 1'b1, "low power");
    chk_bit(mod_oe, 1'b0, "pin 4 driving");
    @(posedge core_clk);
    strap_hi <= 1'b0;
    strap_lo <= 1'b1;
    chk_sel(5'h16, 1'b1, 10'h078);
    chk_bit(mod_out | ref_out, 1'b0, "clocks running");
    @(posedge core_clk);
    power_down_n <= 1'b1;
    settle(6);
    chk_bit(low_power, 1'b0, "low power stuck");
    end_of_test();
  end
  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end
endmodule
